// ### verilog/vsr_register_file.sv
`timescale 1ns/1ns
`include "vsr_defs.svh"
module vsr_register_file #(
  parameter logic [7:0] BOOT_A = 8'h00,
  parameter logic [7:0] BOOT_B = 8'h00
) (
  // Clock and reset (reset is enable low)
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Decoded bus commands from the framing logic
  input  wire logic       cmd_valid_i,
  input  wire logic [2:0] cmd_code_i,
  input  wire logic       cmd_reg_i,
  input  wire logic [7:0] cmd_payload_i,
  input  wire logic [7:0] error_set_i,
  input  wire logic       error_reg_i,
  // Answer to the framing logic
  output logic            ack_valid_o,
  output logic      [1:0] ack_code_o,
  output logic      [7:0] ack_data_o,
  // Pins from the board
  input  wire logic [7:0] thermistor_input_a_i,
  input  wire logic [7:0] thermistor_input_b_i,
  input  wire logic [1:0] output_settled_cmp_i,
  input  wire logic [1:0] fault_i,
  input  wire logic [2:0] current_limit_strap_a_i,
  input  wire logic [2:0] current_limit_strap_b_i,
  input  wire logic       slew_rate_strap_a_i,
  input  wire logic       slew_rate_strap_b_i,
  input  wire logic [1:0] phase_count_a_i,
  input  wire logic [1:0] phase_count_b_i,
  // Pins to the board and regulation loop
  output logic            alert_n_o,
  output logic            thermal_hot_out_n_o,
  output logic      [1:0] regulator_on_o,
  output logic      [1:0] power_good_out_o,
  output logic      [7:0] vid_target_a_o,
  output logic      [7:0] vid_target_b_o,
  output logic      [2:0] power_state_a_o,
  output logic      [2:0] power_state_b_o
);

  vsr_pkg::vsr_state_t r_reg;
  vsr_pkg::vsr_state_t r_next;

  logic [31:0]     pins_s;
  logic [7:0]      zone_a_s;
  logic [7:0]      zone_b_s;
  logic [1:0]      settle_s;
  logic [1:0]      fault_s;
  logic [1:0][2:0] cls_s;
  logic [1:0]      slew_s;
  logic [1:0][1:0] phase_s;
  logic [1:0][7:0] dec_icc;
  logic [1:0][7:0] dec_srf;
  logic [1:0][7:0] dec_srs;
  logic [1:0]      dec_off;
  logic [1:0][7:0] boot_code;

  // All board pins cross into the clock domain together
  vsr_sync2 #(.WIDTH(32)) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({thermistor_input_a_i, thermistor_input_b_i, output_settled_cmp_i, fault_i,
                 current_limit_strap_a_i, current_limit_strap_b_i,
                 slew_rate_strap_a_i, slew_rate_strap_b_i, phase_count_a_i, phase_count_b_i}),
    .sync_o    (pins_s)
  );

  // Unpack the synchronised pins
  assign {zone_a_s, zone_b_s, settle_s, fault_s, cls_s[0], cls_s[1],
          slew_s[0], slew_s[1], phase_s[0], phase_s[1]} = pins_s;
  assign boot_code = {BOOT_B, BOOT_A};

  // One strap decoder per regulator
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_strap
      vsr_strap_decode u_dec (
        .level_i    (cls_s[g]),
        .phases_i   (phase_s[g]),
        .slew_sel_i (slew_s[g]),
        .icc_o      (dec_icc[g]),
        .off_band_o (dec_off[g]),
        .fast_slew_rate_o  (dec_srf[g]),
        .slow_slew_rate_o  (dec_srs[g])
      );
    end
  endgenerate

  // Address decode shared by the address and read commands
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `VSR_ADR_PRIMARY, `VSR_ADR_ERROR, `VSR_ADR_ZONE, `VSR_ADR_LAST, `VSR_ADR_ICC,
      `VSR_ADR_TLIM, `VSR_ADR_SRF, `VSR_ADR_SRS, `VSR_ADR_BOOT, `VSR_ADR_CEIL,
      `VSR_ADR_VID, `VSR_ADR_PS, `VSR_ADR_OFS, `VSR_ADR_CFG, `VSR_ADR_SCR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  // Next state: straps, commands, then events so a set beats a same-cycle clear
  always_comb begin
    logic [1:0]      set_pend;
    logic [1:0][7:0] zone;
    logic            t97_now;
    logic signed [9:0] sum;
    int              i;
    set_pend = 2'b00;
    zone     = {zone_b_s, zone_a_s};
    t97_now  = zone_a_s[`VSR_ZONE_97] | zone_b_s[`VSR_ZONE_97];
    sum      = '0;
    i        = int'(cmd_reg_i);
    r_next   = r_reg;
    r_next.ack_v = 1'b0;
    r_next.ack_c = `VSR_ACK;
    r_next.ack_d = `VSR_BYTE_ZERO;
    // Straps are caught once the synchroniser has filled after enable
    if (!r_reg.captured) begin
      r_next.cap_cnt = r_reg.cap_cnt + 2'h1;
      if (r_reg.cap_cnt == `VSR_STRAP_WAIT) begin
        r_next.captured = 1'b1;
        for (int k = 0; k < 2; k++) begin
          r_next.icc[k]      = dec_icc[k];
          r_next.srf[k]      = dec_srf[k];
          r_next.srs[k]      = dec_srs[k];
          r_next.off_band[k] = dec_off[k];
          r_next.vid[k]      = boot_code[k];
          r_next.slewing[k]  = boot_code[k] != `VSR_BYTE_ZERO;
        end
      end
    end
    // Settle detection on the stale target only
    for (int k = 0; k < 2; k++) begin
      if (r_reg.slewing[k] && settle_s[k]) begin
        r_next.slewing[k] = 1'b0;
        r_next.settled[k] = 1'b1;
        set_pend[k]       = 1'b1;
      end
      r_next.t97[k] = t97_now;
      if (t97_now && !r_reg.t97[k]) begin
        set_pend[k] = 1'b1;
      end
    end
    // Command decode for the addressed regulator
    if (cmd_valid_i) begin
      r_next.ack_v = 1'b1;
      case (cmd_code_i)
        `VSR_CMD_FAST, `VSR_CMD_SLOW, `VSR_CMD_DECAY: begin
          if (r_reg.cfg[i][`VSR_CFG_LOCK]) begin
            r_next.ack_c = `VSR_REJ;
          end else if (cmd_payload_i > r_reg.ceil[i]) begin
            r_next.ack_c = `VSR_NAK;
          end else if (cmd_code_i == `VSR_CMD_DECAY && cmd_payload_i > r_reg.vid[i]) begin
            r_next.ack_c = `VSR_REJ;
          end else if (cmd_payload_i != r_reg.vid[i]) begin
            r_next.vid[i]     = cmd_payload_i;
            r_next.slewing[i] = 1'b1;
            r_next.settled[i] = 1'b0;
            if (cmd_code_i != `VSR_CMD_DECAY) begin
              r_next.ps[i] = `VSR_PS_RST;
            end
          end
        end
        `VSR_CMD_PS: begin
          if (r_reg.cfg[i][`VSR_CFG_LOCK]) begin
            r_next.ack_c = `VSR_REJ;
          end else if (cmd_payload_i > `VSR_PS_MAX || r_reg.slewing[i]) begin
            r_next.ack_c = `VSR_REJ;
          end else begin
            r_next.ps[i] = cmd_payload_i[2:0];
          end
        end
        `VSR_CMD_ADR: begin
          if (addr_ok(cmd_payload_i)) begin
            r_next.scr[i] = cmd_payload_i;
          end else begin
            r_next.ack_c = `VSR_REJ;
          end
        end
        `VSR_CMD_DAT: begin
          // Only master-programmed registers take data
          case (r_reg.scr[i])
            `VSR_ADR_CEIL: r_next.ceil[i] = cmd_payload_i;
            `VSR_ADR_OFS:  r_next.ofs[i]  = cmd_payload_i;
            `VSR_ADR_CFG:  r_next.cfg[i]  = cmd_payload_i[1:0];
            `VSR_ADR_SCR:  r_next.scr[i]  = cmd_payload_i;
            default:       r_next.scr[i]  = r_reg.scr[i];
          endcase
        end
        `VSR_CMD_GET: begin
          if (!addr_ok(cmd_payload_i)) begin
            r_next.ack_c = `VSR_REJ;
          end
          case (cmd_payload_i)
            `VSR_ADR_PRIMARY: begin
              r_next.ack_d = {6'h00, r_reg.t97[i], r_reg.settled[i]};
              r_next.pend[i] = 1'b0;            // Read drops this regulator's hold on alert
            end
            `VSR_ADR_ERROR: begin
              r_next.ack_d   = r_reg.err[i];
              r_next.last[i] = r_reg.err[i];
              r_next.err[i]  = `VSR_BYTE_ZERO;
            end
            `VSR_ADR_ZONE: r_next.ack_d = zone[i];
            `VSR_ADR_LAST: r_next.ack_d = r_reg.last[i];
            `VSR_ADR_ICC:  r_next.ack_d = r_reg.icc[i];
            `VSR_ADR_TLIM: r_next.ack_d = `VSR_TEMP_LIMIT;
            `VSR_ADR_SRF:  r_next.ack_d = r_reg.srf[i];
            `VSR_ADR_SRS:  r_next.ack_d = r_reg.srs[i];
            `VSR_ADR_BOOT: r_next.ack_d = boot_code[i];
            `VSR_ADR_CEIL: r_next.ack_d = r_reg.ceil[i];
            `VSR_ADR_VID:  r_next.ack_d = r_reg.vid[i];
            `VSR_ADR_PS:   r_next.ack_d = {5'h00, r_reg.ps[i]};
            `VSR_ADR_OFS:  r_next.ack_d = r_reg.ofs[i];
            `VSR_ADR_CFG:  r_next.ack_d = {6'h00, r_reg.cfg[i]};
            `VSR_ADR_SCR:  r_next.ack_d = r_reg.scr[i];
            default:       r_next.ack_d = `VSR_BYTE_ZERO;
          endcase
        end
        default: r_next.ack_c = `VSR_REJ;
      endcase
    end
    // Events land after clears, so nothing is lost
    r_next.err[error_reg_i] = r_next.err[error_reg_i] | error_set_i;
    r_next.pend             = r_next.pend | set_pend;
    r_next.alert_n          = ~|r_next.pend;
    // Output targets and power-good per regulator
    for (int k = 0; k < 2; k++) begin
      sum = $signed({2'b00, r_next.vid[k]}) + $signed({{2{r_next.ofs[k][7]}}, r_next.ofs[k]});
      if (r_next.vid[k] == `VSR_BYTE_ZERO) begin
        r_next.vout[k] = `VSR_BYTE_ZERO;
      end else if (sum[9] || sum == '0) begin
        r_next.vout[k] = `VSR_VID_LOW;          // Never let an offset switch it off
      end else if (sum[8]) begin
        r_next.vout[k] = `VSR_VID_TOP;
      end else begin
        r_next.vout[k] = sum[7:0];
      end
      r_next.reg_on[k] = r_next.captured && !r_next.off_band[k] &&
                         r_next.vid[k] != `VSR_BYTE_ZERO;
      r_next.pg[k]     = r_next.captured && !r_next.off_band[k] && !fault_s[k] &&
                         (r_next.vid[k] != `VSR_BYTE_ZERO ||
                          r_next.cfg[k][`VSR_CFG_HOLD]);
    end
    // Independent of commands and registers
    r_next.hot_n = ~(zone_a_s[`VSR_ZONE_100] | zone_b_s[`VSR_ZONE_100]);
  end

  // Enable low restores every default
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg         <= '0;
      r_reg.ceil    <= {`VSR_CEIL_RST, `VSR_CEIL_RST};
      r_reg.vid     <= {`VSR_BYTE_ZERO, `VSR_BYTE_ZERO};
      r_reg.ofs     <= {`VSR_BYTE_ZERO, `VSR_BYTE_ZERO};
      r_reg.cfg     <= {`VSR_CFG_RST, `VSR_CFG_RST};
      r_reg.ps      <= {`VSR_PS_RST, `VSR_PS_RST};
      r_reg.ack_c   <= `VSR_ACK;
      r_reg.alert_n <= 1'b1;
      r_reg.hot_n   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state flops
  assign ack_valid_o         = r_reg.ack_v;
  assign ack_code_o          = r_reg.ack_c;
  assign ack_data_o          = r_reg.ack_d;
  assign alert_n_o           = r_reg.alert_n;
  assign thermal_hot_out_n_o = r_reg.hot_n;
  assign regulator_on_o      = r_reg.reg_on;
  assign power_good_out_o    = r_reg.pg;
  assign vid_target_a_o      = r_reg.vout[0];
  assign vid_target_b_o      = r_reg.vout[1];
  assign power_state_a_o     = r_reg.ps[0];
  assign power_state_b_o     = r_reg.ps[1];

  // Checks
  logic cmd_set_vid;
  logic cmd_get;
  assign cmd_set_vid = cmd_valid_i && (cmd_code_i == `VSR_CMD_FAST || cmd_code_i == `VSR_CMD_SLOW);
  assign cmd_get     = cmd_valid_i && cmd_code_i == `VSR_CMD_GET;

  property p_hot;
    @(posedge clk_i) disable iff (!reset_n_i)
    (zone_a_s[`VSR_ZONE_100] || zone_b_s[`VSR_ZONE_100]) |=> !thermal_hot_out_n_o;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal hot not pulled low");

  property p_t97;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(zone_a_s[`VSR_ZONE_97] | zone_b_s[`VSR_ZONE_97]) |=> !alert_n_o;
  endproperty
  a_t97: assert property (p_t97) else $error("alert missing on 97 percent zone");

  property p_lock;
    @(posedge clk_i) disable iff (!reset_n_i)
    (cmd_set_vid || (cmd_valid_i && cmd_code_i == `VSR_CMD_PS)) &&
    r_reg.cfg[cmd_reg_i][`VSR_CFG_LOCK] |=> ack_code_o == `VSR_REJ && $stable(r_reg.vid);
  endproperty
  a_lock: assert property (p_lock) else $error("locked command not rejected");

  property p_ceil;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_set_vid && !r_reg.cfg[cmd_reg_i][`VSR_CFG_LOCK] && cmd_payload_i > r_reg.ceil[cmd_reg_i]
    |=> ack_code_o == `VSR_NAK && $stable(r_reg.vid);
  endproperty
  a_ceil: assert property (p_ceil) else $error("VID above ceiling accepted");

  property p_ps_range;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && cmd_code_i == `VSR_CMD_PS && cmd_payload_i > `VSR_PS_MAX
    |=> ack_code_o == `VSR_REJ ##0 $stable(r_reg.ps);
  endproperty
  a_ps_range: assert property (p_ps_range) else $error("bad power state accepted");

  property p_ps_exit;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_set_vid && !r_reg.cfg[cmd_reg_i][`VSR_CFG_LOCK] &&
    cmd_payload_i <= r_reg.ceil[cmd_reg_i] && cmd_payload_i != r_reg.vid[cmd_reg_i]
    |=> r_reg.ps[$past(cmd_reg_i)] == `VSR_PS_RST;
  endproperty
  a_ps_exit: assert property (p_ps_exit) else $error("VID change kept low power");

  property p_settle;
    @(posedge clk_i) disable iff (!reset_n_i)
    r_reg.slewing[0] && settle_s[0] && !cmd_valid_i |=> r_reg.settled[0] && !alert_n_o;
  endproperty
  a_settle: assert property (p_settle) else $error("settled flag or alert missing");

  property p_err_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_get && cmd_payload_i == `VSR_ADR_ERROR && error_set_i == `VSR_BYTE_ZERO
    |=> r_reg.last[$past(cmd_reg_i)] == ack_data_o && r_reg.err[$past(cmd_reg_i)] == 8'h00;
  endproperty
  a_err_read: assert property (p_err_read) else $error("error status read not copied");

  property p_adr;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && cmd_code_i == `VSR_CMD_ADR && addr_ok(cmd_payload_i)
    |=> r_reg.scr[$past(cmd_reg_i)] == $past(cmd_payload_i);
  endproperty
  a_adr: assert property (p_adr) else $error("address pointer not stored");

  property p_ro;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_valid_i && cmd_code_i == `VSR_CMD_DAT && r_reg.scr[cmd_reg_i] == `VSR_ADR_ICC && r_reg.captured
    |=> $stable(r_reg.icc) && $stable(r_reg.vid);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only register written");

  property p_tlim;
    @(posedge clk_i) disable iff (!reset_n_i)
    cmd_get && cmd_payload_i == `VSR_ADR_TLIM |=> ack_valid_o && ack_data_o == 8'h64;
  endproperty
  a_tlim: assert property (p_tlim) else $error("temperature limit misread");

  property p_pg_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    r_reg.vid[0] == 8'h00 && !r_reg.cfg[0][`VSR_CFG_HOLD] |-> !power_good_out_o[0] && !regulator_on_o[0];
  endproperty
  a_pg_zero: assert property (p_pg_zero) else $error("power good high at zero VID");

  c_settle: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(r_reg.settled[1]));
  c_nak:    cover property (@(posedge clk_i) disable iff (!reset_n_i) ack_code_o == `VSR_NAK);
  c_lock:   cover property (@(posedge clk_i) disable iff (!reset_n_i)
                            ack_valid_o && r_reg.cfg[0][`VSR_CFG_LOCK]);
  c_hot:    cover property (@(posedge clk_i) disable iff (!reset_n_i) !thermal_hot_out_n_o);

endmodule : vsr_register_file

// ### verilog/vsr_defs.svh
`ifndef VSR_DEFS_SVH
`define VSR_DEFS_SVH

// Register addresses
`define VSR_ADR_PRIMARY   8'h10
`define VSR_ADR_ERROR     8'h11
`define VSR_ADR_ZONE      8'h12
`define VSR_ADR_LAST      8'h1C
`define VSR_ADR_ICC       8'h21
`define VSR_ADR_TLIM      8'h22
`define VSR_ADR_SRF       8'h24
`define VSR_ADR_SRS       8'h25
`define VSR_ADR_BOOT      8'h26
`define VSR_ADR_CEIL      8'h30
`define VSR_ADR_VID       8'h31
`define VSR_ADR_PS        8'h32
`define VSR_ADR_OFS       8'h33
`define VSR_ADR_CFG       8'h34
`define VSR_ADR_SCR       8'h35

// Reset values and fixed contents
`define VSR_CEIL_RST      8'hFB
`define VSR_BYTE_ZERO     8'h00
`define VSR_PS_RST        3'h0
`define VSR_CFG_RST       2'h0
`define VSR_TEMP_LIMIT    8'h64
`define VSR_VID_TOP       8'hFF
`define VSR_VID_LOW       8'h01
`define VSR_PS_MAX        8'h03

// Field positions
`define VSR_ZONE_97       6
`define VSR_ZONE_100      7
`define VSR_CFG_HOLD      0
`define VSR_CFG_LOCK      1
`define VSR_ST1_SETTLED   0
`define VSR_ST1_THERM     1

// Acknowledge codes
`define VSR_ACK           2'b00
`define VSR_NAK           2'b01
`define VSR_REJ           2'b11

// Command codes
`define VSR_CMD_FAST      3'h1
`define VSR_CMD_SLOW      3'h2
`define VSR_CMD_DECAY     3'h3
`define VSR_CMD_PS        3'h4
`define VSR_CMD_ADR       3'h5
`define VSR_CMD_DAT       3'h6
`define VSR_CMD_GET       3'h7

// Strap decoding
`define VSR_STRAP_WAIT    2'h3
`define VSR_LVL_GND       3'h0
`define VSR_LVL_VCC       3'h7
`define VSR_ICC_STEP      13'h000A
`define VSR_FAST_SLEW_RATE_LO    8'h0A
`define VSR_FAST_SLEW_RATE_HI    8'h14
`define VSR_SLOW_SLEW_RATE_SHIFT 2

`endif

// ### verilog/vsr_pkg.sv
package vsr_pkg;

  // Whole state of the register file, both regulators side by side
  typedef struct packed {
    logic [1:0][7:0] ceil;
    logic [1:0][7:0] vid;
    logic [1:0][7:0] ofs;
    logic [1:0][7:0] scr;
    logic [1:0][7:0] err;
    logic [1:0][7:0] last;
    logic [1:0][7:0] icc;
    logic [1:0][7:0] srf;
    logic [1:0][7:0] srs;
    logic [1:0][7:0] vout;
    logic [1:0][2:0] ps;
    logic [1:0][1:0] cfg;
    logic [1:0]      slewing;
    logic [1:0]      settled;
    logic [1:0]      t97;
    logic [1:0]      pend;
    logic [1:0]      off_band;
    logic [1:0]      reg_on;
    logic [1:0]      pg;
    logic [1:0]      cap_cnt;
    logic            captured;
    logic            ack_v;
    logic [1:0]      ack_c;
    logic [7:0]      ack_d;
    logic            alert_n;
    logic            hot_n;
  } vsr_state_t;

endpackage : vsr_pkg

// ### verilog/vsr_sync2.sv
`timescale 1ns/1ns
module vsr_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } vsr_sync_state_t;

  vsr_sync_state_t r_reg;
  vsr_sync_state_t r_next;

  // First stage feeds only the second stage
  always_comb begin
    r_next        = r_reg;
    r_next.meta   = async_i;
    r_next.stable = r_reg.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_o = r_reg.stable;

endmodule : vsr_sync2

// ### verilog/vsr_strap_decode.sv
`timescale 1ns/1ns
`include "vsr_defs.svh"
module vsr_strap_decode (
  // Strap levels, already synchronised
  input  wire logic [2:0] level_i,
  input  wire logic [1:0] phases_i,
  input  wire logic       slew_sel_i,
  // Decoded capability values
  output logic      [7:0] icc_o,
  output logic            off_band_o,
  output logic      [7:0] fast_slew_rate_o,
  output logic      [7:0] slow_slew_rate_o
);

  logic [12:0] product;

  // Per-phase limit times active phases; fits a byte for all legal levels
  always_comb begin
    product    = 13'(level_i) * `VSR_ICC_STEP * 13'(phases_i);
    icc_o      = product[7:0];
    // Strap tied to a rail lies outside every band
    off_band_o = (level_i == `VSR_LVL_GND) || (level_i == `VSR_LVL_VCC);
    fast_slew_rate_o  = slew_sel_i ? `VSR_FAST_SLEW_RATE_HI : `VSR_FAST_SLEW_RATE_LO;
    slow_slew_rate_o  = fast_slew_rate_o >> `VSR_SLOW_SLEW_RATE_SHIFT;
  end

endmodule : vsr_strap_decode

// ### bench/vsr_master_model.sv
`timescale 1ns/1ns
module vsr_master_model (
  // Clock
  input  wire logic       clk_i,
  // Command side
  output logic            cmd_valid_o,
  output logic      [2:0] cmd_code_o,
  output logic            cmd_reg_o,
  output logic      [7:0] cmd_payload_o,
  // Answer side
  input  wire logic       ack_valid_i,
  input  wire logic [1:0] ack_code_i,
  input  wire logic [7:0] ack_data_i
);
  // Idle bus; payload parked on a live pattern
  initial begin
    cmd_valid_o   = 1'b0;
    cmd_code_o    = 3'h0;
    cmd_reg_o     = 1'b0;
    cmd_payload_o = 8'hA5;
  end
  // Hold to the taking edge, then take the answer; no ack gives 3FFh
  task automatic send(input logic r, input logic [2:0] c, input logic [7:0] p,
                      output logic [9:0] a);
    @(posedge clk_i);
    #2;
    cmd_valid_o   = 1'b1;
    cmd_code_o    = c;
    cmd_reg_o     = r;
    cmd_payload_o = p;
    @(posedge clk_i);
    #2;
    cmd_valid_o   = 1'b0;
    cmd_payload_o = ~p;
    a = (ack_valid_i === 1'b1) ? {ack_code_i, ack_data_i} : 10'h3FF;
  endtask : send
endmodule : vsr_master_model

// ### bench/test_vsr_register_file.sv
`timescale 1ns/1ns
module test_vsr_register_file;
  // Pins
  logic       clk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i, cmd_reg_i, error_reg_i = 1'b0;
  logic [7:0] cmd_payload_i, error_set_i = 8'h00, thermistor_input_a_i = 8'h00;
  logic [7:0] thermistor_input_b_i = 8'h00, vid_target_a_o, vid_target_b_o, ack_data_o;
  logic [1:0] ack_code_o, output_settled_cmp_i = 2'b00, regulator_on_o, power_good_out_o;
  logic [2:0] cmd_code_i, power_state_a_o, power_state_b_o, strap_a = 3'h3;
  logic [1:0] phases_a = 2'h2;
  logic [1:0] fault = 2'b00;
  logic       rsel = 1'b0;
  logic       ack_valid_o, alert_n_o, thermal_hot_out_n_o;
  logic [9:0] a;
  int         err_count = 0, compares = 0, cyc = 0;
  vsr_register_file u_vsr_register_file (.clk_i, .reset_n_i, .cmd_valid_i, .cmd_code_i,
    .cmd_reg_i, .cmd_payload_i, .error_set_i, .error_reg_i, .ack_valid_o, .ack_code_o,
    .ack_data_o, .thermistor_input_a_i, .thermistor_input_b_i, .output_settled_cmp_i,
    .fault_i(fault), .current_limit_strap_a_i(strap_a), .current_limit_strap_b_i(3'h0),
    .slew_rate_strap_a_i(1'b1), .slew_rate_strap_b_i(1'b0), .phase_count_a_i(phases_a),
    .phase_count_b_i(2'h1), .alert_n_o, .thermal_hot_out_n_o, .regulator_on_o,
    .power_good_out_o, .vid_target_a_o, .vid_target_b_o, .power_state_a_o, .power_state_b_o);
  vsr_master_model u_vsr_master_model (.clk_i, .cmd_valid_o(cmd_valid_i),
    .cmd_code_o(cmd_code_i), .cmd_reg_o(cmd_reg_i), .cmd_payload_o(cmd_payload_i),
    .ack_valid_i(ack_valid_o), .ack_code_i(ack_code_o), .ack_data_i(ack_data_o));
  // Shared helpers
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : w
  task automatic cmd(input logic [2:0] c, input logic [7:0] p, input logic [9:0] e);
    u_vsr_master_model.send(rsel, c, p, a);
    chk(a, e);
  endtask : cmd
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    cmd(3'h5, r, 10'h000);
    cmd(3'h6, d, 10'h000);
  endtask : wr
  // Scenarios
  task automatic t_therm();
    thermistor_input_b_i = 8'h80;
    w(5);
    chk({9'h000, thermal_hot_out_n_o}, 10'h000);
    thermistor_input_a_i = 8'h40;
    w(5);
    chk({9'h000, alert_n_o}, 10'h000);
    cmd(3'h7, 8'h10, 10'h002);
    rsel = 1'b1;
    cmd(3'h7, 8'h10, 10'h002);
    rsel = 1'b0;
    chk({9'h000, alert_n_o}, 10'h001);
    thermistor_input_a_i = 8'h00;
    thermistor_input_b_i = 8'h00;
  endtask : t_therm
  task automatic t_defaults();
    cmd(3'h7, 8'h30, 10'h0FB);
    cmd(3'h7, 8'h31, 10'h000);
    cmd(3'h7, 8'h33, 10'h000);
    cmd(3'h7, 8'h21, 10'h03C);
    cmd(3'h7, 8'h24, 10'h014);
    cmd(3'h7, 8'h25, 10'h005);
    cmd(3'h7, 8'h40, 10'h300);
    wr(8'h22, 8'h00);
    cmd(3'h7, 8'h22, 10'h064);
    chk({8'h00, regulator_on_o}, 10'h000);
    chk({9'h000, thermal_hot_out_n_o}, 10'h001);
  endtask : t_defaults
  task automatic t_vid();
    wr(8'h30, 8'h40);
    cmd(3'h1, 8'h41, 10'h100);
    cmd(3'h1, 8'h40, 10'h000);
    cmd(3'h7, 8'h31, 10'h040);
    wr(8'h33, 8'h03);
    chk({2'b00, vid_target_a_o}, 10'h043);
    chk({8'h00, power_good_out_o}, 10'h001);
    chk({8'h00, regulator_on_o}, 10'h001);
    wr(8'h33, 8'hFD);
    chk({2'b00, vid_target_a_o}, 10'h03D);
    cmd(3'h7, 8'h35, 10'h033);
  endtask : t_vid
  task automatic t_ps();
    output_settled_cmp_i = 2'b01;
    w(4);
    chk({9'h000, alert_n_o}, 10'h000);
    cmd(3'h4, 8'h04, 10'h300);
    cmd(3'h4, 8'h03, 10'h000);
    chk({7'h00, power_state_a_o}, 10'h003);
    cmd(3'h7, 8'h10, 10'h001);
    chk({9'h000, alert_n_o}, 10'h001);
    output_settled_cmp_i = 2'b00;
    cmd(3'h1, 8'h20, 10'h000);
    chk({7'h00, power_state_a_o}, 10'h000);
    w(165);
  endtask : t_ps
  task automatic t_lock();
    wr(8'h34, 8'h02);
    cmd(3'h1, 8'h30, 10'h300);
    cmd(3'h4, 8'h01, 10'h300);
    wr(8'h34, 8'h00);
    cmd(3'h2, 8'h30, 10'h000);
    wr(8'h34, 8'h01);
    cmd(3'h1, 8'h00, 10'h000);
    chk({6'h00, regulator_on_o, power_good_out_o}, 10'h001);
    fault = 2'b01;
    w(3);
    chk({8'h00, power_good_out_o}, 10'h000);
    fault = 2'b00;
    wr(8'h34, 8'h00);
    chk({8'h00, power_good_out_o}, 10'h000);
  endtask : t_lock
  task automatic t_err();
    error_set_i = 8'h05;
    w(1);
    error_set_i = 8'h00;
    cmd(3'h7, 8'h11, 10'h005);
    cmd(3'h7, 8'h1C, 10'h005);
    cmd(3'h7, 8'h11, 10'h000);
  endtask : t_err
  // Second regulator: own copy, decay keeps its power state
  task automatic t_regb();
    rsel = 1'b1;
    cmd(3'h1, 8'h10, 10'h000);
    chk({2'b00, vid_target_b_o}, 10'h010);
    chk({9'h000, regulator_on_o[1]}, 10'h000);
    cmd(3'h4, 8'h02, 10'h300);
    output_settled_cmp_i = 2'b10;
    w(4);
    chk({9'h000, alert_n_o}, 10'h000);
    output_settled_cmp_i = 2'b00;
    cmd(3'h7, 8'h10, 10'h001);
    cmd(3'h4, 8'h02, 10'h000);
    cmd(3'h3, 8'h20, 10'h300);
    cmd(3'h3, 8'h08, 10'h000);
    chk({4'h0, power_state_b_o, power_state_a_o}, 10'h010);
    chk({2'b00, vid_target_b_o}, 10'h008);
    cmd(3'h7, 8'h30, 10'h0FB);
    rsel = 1'b0;
  endtask : t_regb
  // Verdict
  task automatic close_out();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Clock and hang guard
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  // Main sequence; mid-run reset at the end
  initial begin
    w(8);
    reset_n_i = 1'b1;
    w(6);
    t_therm();
    t_defaults();
    t_vid();
    t_ps();
    t_lock();
    t_err();
    t_regb();
    reset_n_i = 1'b0;
    w(2);
    reset_n_i = 1'b1;
    cmd(3'h7, 8'h30, 10'h0FB);
    cmd(3'h7, 8'h33, 10'h000);
    chk({2'b00, vid_target_b_o}, 10'h000);
    chk({4'h0, power_state_b_o, power_state_a_o}, 10'h000);
    close_out();
  end
endmodule : test_vsr_register_file
